// ==== inc/mmf_pkg.sv ====
// Purpose: Shared constants and types of the motion monitor fault supervision core
// Assumes: 40 MHz system clock
// Notes: Fault injection and overlap codes are the configured setting values
`default_nettype none
package mmf_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int HZ_PER_KHZ = 1000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int TICK_MS_CYC = CLK_HZ / HZ_PER_KHZ;
    localparam int MIN_FILT_US = 100;
    localparam int MIN_FILT_CYC = (CLK_HZ / HZ_PER_MHZ) * MIN_FILT_US;

    localparam int POS_W = 32;
    localparam int LIM_W = 24;
    localparam int FREQ_W = 24;
    localparam int FILT_W = 10;
    localparam int ERR_W = 21;
    localparam int PUD_W = 15;
    localparam int CAS_W = 17;
    localparam int MSCNT_W = 16;
    localparam int GAP_W = 12;
    localparam int QCNT_W = 5;
    localparam int NUM_SENS = 2;

    localparam logic [PUD_W-1:0] PUD_DEFAULT_MS = 15'h0064;
    localparam logic [1:0] FI_FORCE = 2'h0;
    localparam logic [1:0] FI_NORMAL = 2'h1;
    localparam logic [1:0] FI_CLEAR = 2'h2;
    localparam logic [1:0] OVL_OFF = 2'h0;
    localparam logic [1:0] OVL_LOW = 2'h1;
    localparam logic [1:0] OVL_HIGH = 2'h2;
    localparam logic [1:0] TYPE_SINGLE_DIR = 2'h3;
    localparam int ERR_BIT_POS = 0;
    localparam int ERR_BIT_OVL = 1;
    localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(MIN_FILT_CYC - 1);
    localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(FREQ_W - 1);

    typedef struct packed {
        logic prog_mode;
        logic cascade_mode;
        logic [1:0] fault_injection_setting;
        logic [LIM_W-1:0] pos_limit;
        logic [PUD_W-1:0] powerup_delay_ms;
        logic [CAS_W-1:0] cascade_delay_ms;
        logic [FILT_W-1:0] filter_strength;
        logic [ERR_W-1:0] store_mask;
        logic [1:0] overlap_mode;
        logic [1:0] sensor_input_type1;
        logic [1:0] sensor_input_type2;
    } mmf_cfg_s;

    typedef struct packed {
        logic [ERR_W-1:0] err_status;
        logic error_out;
        logic stored_error_at_startup;
        logic eval_active;
    } mmf_status_s;
endpackage : mmf_pkg
`default_nettype wire

// ==== hw/mmf_freq_filter.sv ====
// Purpose: First-order smoothing of one measured input frequency
// Assumes: freq_stb marks a new measurement, per sampling time or per period
// Notes: Serial divider, updates spaced at least 100 us apart
`timescale 1ns/1ps
`default_nettype none
module mmf_freq_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [mmf_pkg::FREQ_W-1:0] freq_in,
    input wire logic freq_stb,
    input wire logic [mmf_pkg::FILT_W-1:0] strength,
    output logic [mmf_pkg::FREQ_W-1:0] freq_out,
    output logic busy
);
    import mmf_pkg::*;

    typedef enum logic [1:0] {FS_IDLE, FS_DIV, FS_APPLY} mmf_fs_e;

    mmf_fs_e state;
    logic [FREQ_W-1:0] sample;
    logic pend;
    logic [GAP_W-1:0] gap;
    logic [FREQ_W-1:0] dividend;
    logic [FREQ_W-1:0] quot;
    logic [FILT_W:0] rem;
    logic [QCNT_W-1:0] bit_cnt;
    logic up;
    logic start;
    logic [FILT_W:0] next_rem_sh;
    logic next_qbit;
    logic [FREQ_W-1:0] step;

    assign start = (state == FS_IDLE) && pend && (gap == GAP_LAST);
    assign busy = (state != FS_IDLE);

    always_comb
    begin
        next_rem_sh = {rem[FILT_W-1:0], dividend[FREQ_W-1]};
        next_qbit = (next_rem_sh >= {1'b0, strength});
        step = (quot == '0 && sample != freq_out) ? FREQ_W'(1) : quot;
    end

    // Newest measurement wins while one is waiting
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample <= '0;
            pend <= 1'b0;
        end
        else if (freq_stb)
        begin
            sample <= freq_in;
            pend <= 1'b1;
        end
        else if (start)
            pend <= 1'b0;
    end

    // Floor on update spacing keeps the filter time above 100 us
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gap <= '0;
        else if (start)
            gap <= '0;
        else if (gap != GAP_LAST)
            gap <= gap + GAP_W'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= FS_IDLE;
            freq_out <= '0;
            dividend <= '0;
            quot <= '0;
            rem <= '0;
            bit_cnt <= '0;
            up <= 1'b0;
        end
        else
        begin
            case (state)
                FS_IDLE:
                begin
                    if (start && strength == '0)
                        freq_out <= sample;
                    else if (start)
                    begin
                        // Step of diff/strength per update: 63 % after strength updates
                        up <= (sample >= freq_out);
                        dividend <= (sample >= freq_out) ? sample - freq_out : freq_out - sample;
                        quot <= '0;
                        rem <= '0;
                        bit_cnt <= '0;
                        state <= FS_DIV;
                    end
                end
                FS_DIV:
                begin
                    rem <= next_qbit ? next_rem_sh - {1'b0, strength} : next_rem_sh;
                    quot <= {quot[FREQ_W-2:0], next_qbit};
                    dividend <= {dividend[FREQ_W-2:0], 1'b0};
                    bit_cnt <= bit_cnt + QCNT_W'(1);
                    if (bit_cnt == QCNT_LAST)
                        state <= FS_APPLY;
                end
                FS_APPLY:
                begin
                    // Minimum step of one so the final value is reached
                    freq_out <= up ? freq_out + step : freq_out - step;
                    state <= FS_IDLE;
                end
                default:
                    state <= FS_IDLE;
            endcase
        end
    end

    bypass_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        (start && strength == '0) |=> (freq_out == $past(sample)))
        else $error("unfiltered sample not passed through");
endmodule : mmf_freq_filter
`default_nettype wire

// ==== hw/mmf_fault_supervisor.sv ====
// Purpose: Fault supervision and input conditioning of a two-sensor motion monitor
// Assumes: Positions and frequencies come from same-clock counters; sensor A levels are pins
// Notes: Stored error record lives outside; this block reads it at reset and requests writes
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Flag error when sensor position difference exceeds limit either direction.
// - Zero position limit disables position deviation detection entirely.
// - Fault injection setting only honoured while in programming mode.
// - Fault injection value zero forces the error status; the code forces only error_out and leaves err_status as it is.
// - Fault injection value two clears every reported error; errors detected in that same cycle stay latched.
// - Evaluation starts only after power-up delay; default one tenth second.
// - Filter strength zero passes frequency unsmoothed; higher means stronger smoothing.
// - Fast inputs: 63/95/100 percent after 1/3/5 sample time times strength.
// - Slow inputs: time constant is period times strength.
// - Filter time never below about 100 us.
// - Store mask selects error classes kept across power-down; zero stores none.
// - At initialisation flag startup error if masked error was stored.
// - Stored errors show in error status whatever their cause now.
// - Overlap check only when both inputs single-lane type three; zero disables.
// - Overlap one flags both low, overlap two flags both high.
// - Separate power-on delay applies in cascade mode.
module mmf_fault_supervisor #(
    parameter int MS_CYCLES = mmf_pkg::TICK_MS_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire mmf_pkg::mmf_cfg_s cfg,
    input wire logic signed [mmf_pkg::POS_W-1:0] pos1,
    input wire logic signed [mmf_pkg::POS_W-1:0] pos2,
    input wire logic sens_a1_pin,
    input wire logic sens_a2_pin,
    input wire logic [mmf_pkg::ERR_W-1:0] ext_err,
    input wire logic [mmf_pkg::NUM_SENS-1:0][mmf_pkg::FREQ_W-1:0] freq_raw,
    input wire logic [mmf_pkg::NUM_SENS-1:0] freq_stb,
    input wire logic [mmf_pkg::ERR_W-1:0] nv_saved,
    output mmf_pkg::mmf_status_s status,
    output logic [mmf_pkg::NUM_SENS-1:0][mmf_pkg::FREQ_W-1:0] freq_filt,
    output logic [mmf_pkg::NUM_SENS-1:0] filt_busy,
    output logic [mmf_pkg::ERR_W-1:0] nv_data,
    output logic nv_wr
);
    import mmf_pkg::*;

    typedef enum logic [1:0] {ST_INIT, ST_WAIT, ST_RUN} mmf_st_e;

    mmf_st_e state;
    logic [1:0] a1_sync;
    logic [1:0] a2_sync;
    logic [MSCNT_W-1:0] ms_cnt;
    logic [CAS_W-1:0] ms_elapsed;
    logic [CAS_W-1:0] delay_ms;
    logic ms_tick;
    logic eval;
    logic [1:0] fi_eff;
    logic clear_req;
    logic force_req;
    logic signed [POS_W:0] pos_diff;
    logic signed [POS_W:0] lim_s;
    logic pos_err;
    logic ovl_armed;
    logic ovl_err;
    logic [ERR_W-1:0] detect;
    logic [ERR_W-1:0] latched;
    logic [ERR_W-1:0] stored;
    logic [ERR_W-1:0] to_store;
    logic startup_err;
    logic error_out;

    // Pin levels pass two flops before any logic looks at them
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a1_sync <= 2'h0;
            a2_sync <= 2'h0;
        end
        else
        begin
            a1_sync <= {a1_sync[0], sens_a1_pin};
            a2_sync <= {a2_sync[0], sens_a2_pin};
        end
    end

    // Programming mode gates the injection setting; outside it acts as normal
    assign fi_eff = cfg.prog_mode ? cfg.fault_injection_setting : FI_NORMAL;
    assign force_req = (fi_eff == FI_FORCE);
    assign clear_req = (fi_eff == FI_CLEAR);

    assign delay_ms = cfg.cascade_mode ? cfg.cascade_delay_ms : CAS_W'(cfg.powerup_delay_ms);
    assign ms_tick = (ms_cnt == MSCNT_W'(MS_CYCLES - 1));
    assign eval = (state == ST_RUN);

    // Millisecond time base for the start-up delays
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_cnt <= '0;
        else if (ms_tick || state != ST_WAIT)
            ms_cnt <= '0;
        else
            ms_cnt <= ms_cnt + MSCNT_W'(1);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_elapsed <= '0;
        else if (state == ST_WAIT && ms_tick && ms_elapsed != '1)
            ms_elapsed <= ms_elapsed + CAS_W'(1);
    end

    // Record is read once in the cycle after reset release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= ST_INIT;
        else
        begin
            case (state)
                ST_INIT:
                    state <= ST_WAIT;
                ST_WAIT:
                    if (ms_elapsed >= delay_ms)
                        state <= ST_RUN;
                ST_RUN:
                    state <= ST_RUN;
                default:
                    state <= ST_INIT;
            endcase
        end
    end

    // Sign-extended compare avoids wrap at the position range ends
    assign pos_diff = {pos1[POS_W-1], pos1} - {pos2[POS_W-1], pos2};
    assign lim_s = signed'({{(POS_W + 1 - LIM_W){1'b0}}, cfg.pos_limit});
    assign pos_err = eval && (cfg.pos_limit != '0) && ((pos_diff > lim_s) || (pos_diff < -lim_s));

    assign ovl_armed = (cfg.sensor_input_type1 == TYPE_SINGLE_DIR) && (cfg.sensor_input_type2 == TYPE_SINGLE_DIR);
    always_comb
    begin
        ovl_err = 1'b0;
        if (eval && ovl_armed)
        begin
            case (cfg.overlap_mode)
                OVL_LOW: ovl_err = !a1_sync[1] && !a2_sync[1];
                OVL_HIGH: ovl_err = a1_sync[1] && a2_sync[1];
                default: ovl_err = 1'b0;
            endcase
        end
    end

    always_comb
    begin
        detect = eval ? ext_err : '0;
        detect[ERR_BIT_POS] = pos_err;
        detect[ERR_BIT_OVL] = ovl_err;
    end

    // New detections win over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            latched <= '0;
        else if (clear_req)
            latched <= detect;
        else
            latched <= latched | detect;
    end

    // Stored classes are loaded at start-up and held in the status
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stored <= '0;
        else if (state == ST_INIT)
            stored <= nv_saved & cfg.store_mask;
        else if (clear_req)
            stored <= '0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            startup_err <= 1'b0;
        else if (state == ST_INIT)
            startup_err <= |(nv_saved & cfg.store_mask);
        else if (clear_req)
            startup_err <= 1'b0;
    end

    // Record updates: add newly latched masked classes, or on clear keep only masked classes detected that cycle
    assign to_store = (latched | detect) & cfg.store_mask;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_data <= '0;
            nv_wr <= 1'b0;
        end
        else if (state == ST_INIT)
        begin
            nv_data <= nv_saved;
            nv_wr <= 1'b0;
        end
        else if (clear_req && nv_data != (detect & cfg.store_mask))
        begin
            nv_data <= detect & cfg.store_mask;
            nv_wr <= 1'b1;
        end
        else if (!clear_req && (to_store & ~nv_data) != '0)
        begin
            nv_data <= nv_data | to_store;
            nv_wr <= 1'b1;
        end
        else
            nv_wr <= 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            error_out <= 1'b0;
        else
            error_out <= force_req || ((latched | stored) != '0);
    end

    assign status.err_status = latched | stored;
    assign status.error_out = error_out;
    assign status.stored_error_at_startup = startup_err;
    assign status.eval_active = eval;

    // Both channels use the same filter; strength is shared
    genvar g;
    generate
        for (g = 0; g < NUM_SENS; g++)
        begin : g_filt
            mmf_freq_filter u_filt (
                .clk(clk),
                .rst_n(rst_n),
                .freq_in(freq_raw[g]),
                .freq_stb(freq_stb[g]),
                .strength(cfg.filter_strength),
                .freq_out(freq_filt[g]),
                .busy(filt_busy[g])
            );
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pos_dev_set_a: assert property ((eval && cfg.pos_limit != '0 && pos_diff > lim_s)
        |=> status.err_status[ERR_BIT_POS])
        else $error("positive position deviation not flagged");

    pos_dev_neg_a: assert property ((eval && cfg.pos_limit != '0 && pos_diff < -lim_s)
        |=> status.err_status[ERR_BIT_POS])
        else $error("negative position deviation not flagged");

    pos_dev_off_a: assert property ((state != ST_INIT && cfg.pos_limit == '0
        && !status.err_status[ERR_BIT_POS]) |=> !latched[ERR_BIT_POS])
        else $error("position error raised with zero limit");

    inject_gate_a: assert property ((!cfg.prog_mode && !$past(error_out) && latched == '0
        && stored == '0) |=> !error_out)
        else $error("injection acted outside programming mode");

    force_error_a: assert property ((cfg.prog_mode && cfg.fault_injection_setting == FI_FORCE)
        |=> error_out)
        else $error("forced error state not shown");

    clear_all_a: assert property ((clear_req && detect == '0) |=> (status.err_status == '0
        && !startup_err))
        else $error("clear value left errors reported");

    startup_hold_a: assert property ((state == ST_WAIT && ms_elapsed < delay_ms)
        |=> (latched == $past(latched)) || $past(clear_req))
        else $error("evaluation before start-up delay");

    init_load_a: assert property ((state == ST_INIT) |=> (startup_err ==
        |($past(nv_saved) & $past(cfg.store_mask))))
        else $error("startup error not taken from record");

    stored_shown_a: assert property ((stored != '0) |=> (error_out || $past(clear_req)))
        else $error("stored error missing from error output");

    overlap_low_a: assert property ((eval && ovl_armed && cfg.overlap_mode == OVL_LOW
        && !a1_sync[1] && !a2_sync[1]) |=> status.err_status[ERR_BIT_OVL])
        else $error("low overlap not flagged");

    overlap_gate_a: assert property ((!ovl_armed || cfg.overlap_mode == OVL_OFF) |-> !ovl_err)
        else $error("overlap evaluated when disabled");

    latch_hold_a: assert property ((!clear_req && state != ST_INIT)
        |=> (status.err_status & $past(status.err_status)) == $past(status.err_status))
        else $error("latched error dropped without clear");

    record_write_a: assert property ((state != ST_INIT && !clear_req && (to_store & ~nv_data) != '0)
        |=> nv_wr ##1 (!nv_wr || $past(clear_req) || ($past(to_store) & ~$past(nv_data)) != '0))
        else $error("masked error not written to record");

    pos_error_c: cover property (eval ##1 status.err_status[ERR_BIT_POS]);
    clear_seq_c: cover property (status.err_status != '0 ##1 clear_req ##1 status.err_status == '0);
    startup_err_c: cover property (state == ST_INIT ##1 startup_err);
    overlap_c: cover property (ovl_err ##1 status.err_status[ERR_BIT_OVL]);
endmodule : mmf_fault_supervisor
`default_nettype wire

// ==== dv/mmf_sensor_model.sv ====
// Purpose: Two encoder channels facing the supervision core
// Assumes: Bench clock domain, one request at a time
// Notes: Raw frequency is scrambled once its strobe has gone
`timescale 1ns/1ps
`default_nettype none
module mmf_sensor_model (
    input wire logic clk,
    output logic signed [mmf_pkg::POS_W-1:0] pos1,
    output logic signed [mmf_pkg::POS_W-1:0] pos2,
    output logic a1,
    output logic a2,
    output logic [mmf_pkg::NUM_SENS-1:0][mmf_pkg::FREQ_W-1:0] freq_raw,
    output logic [mmf_pkg::NUM_SENS-1:0] freq_stb
);
    import mmf_pkg::*;
    initial
    begin
        {pos1, pos2, freq_raw, freq_stb} = '0;
        a1 = 1'b1;
        a2 = 1'b0;
    end
    task automatic set_pos(input logic signed [POS_W-1:0] p1, input logic signed [POS_W-1:0] p2);
        @(posedge clk);
        pos1 <= p1;
        pos2 <= p2;
    endtask : set_pos
    task automatic set_pins(input logic l1, input logic l2);
        @(posedge clk);
        a1 <= l1;
        a2 <= l2;
    endtask : set_pins
    // Value only valid with its strobe, so never leave it readable
    task automatic send_freq(input int ch, input logic [FREQ_W-1:0] f);
        @(posedge clk);
        freq_raw[ch] <= f;
        freq_stb[ch] <= 1'b1;
        @(posedge clk);
        freq_raw[ch] <= ~f;
        freq_stb[ch] <= 1'b0;
    endtask : send_freq
endmodule : mmf_sensor_model
`default_nettype wire

// ==== dv/mmf_fault_supervisor_tb.sv ====
// Purpose: Self-checking bench of the fault supervision core
// Assumes: Millisecond tick shortened to a few cycles
// Notes: Start-up figures carry a small tolerance for pipeline stages
`timescale 1ns/1ps
`default_nettype none
module mmf_fault_supervisor_tb;
    import mmf_pkg::*;
    localparam int MS = 4;
    logic clk;
    logic rst_n;
    mmf_cfg_s cfg;
    logic [ERR_W-1:0] ext_err;
    logic [ERR_W-1:0] nv_saved;
    mmf_status_s status;
    logic signed [POS_W-1:0] pos1;
    logic signed [POS_W-1:0] pos2;
    logic a1;
    logic a2;
    logic [NUM_SENS-1:0][FREQ_W-1:0] freq_raw;
    logic [NUM_SENS-1:0][FREQ_W-1:0] freq_filt;
    logic [NUM_SENS-1:0] freq_stb;
    logic [NUM_SENS-1:0] filt_busy;
    logic [ERR_W-1:0] nv_data;
    logic nv_wr;
    int n_mismatch = 0;
    int check_count = 0;
    int nv_wr_seen = 0;
    mmf_fault_supervisor #(.MS_CYCLES(MS)) mmf_fault_supervisor_i (.clk(clk), .rst_n(rst_n), .cfg(cfg),
        .pos1(pos1), .pos2(pos2), .sens_a1_pin(a1), .sens_a2_pin(a2), .ext_err(ext_err), .freq_raw(freq_raw),
        .freq_stb(freq_stb), .nv_saved(nv_saved), .status(status), .freq_filt(freq_filt),
        .filt_busy(filt_busy), .nv_data(nv_data), .nv_wr(nv_wr));
    mmf_sensor_model mmf_sensor_model_i (.clk(clk), .pos1(pos1), .pos2(pos2), .a1(a1), .a2(a2),
        .freq_raw(freq_raw), .freq_stb(freq_stb));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk)
        if (nv_wr === 1'b1)
            nv_wr_seen++;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic fail(input string m);
        n_mismatch++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail
    task automatic chk_flag(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp)
            fail(m);
    endtask : chk_flag
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
            fail(m);
    endtask : chk_word
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic do_reset(input logic [ERR_W-1:0] saved);
        @(posedge clk);
        rst_n <= 1'b0;
        nv_saved <= saved;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
    endtask : do_reset
    task automatic wait_eval(output int n);
        n = 0;
        while (status.eval_active !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 200)
            begin
                fail("evaluation never started");
                wrap_up();
            end
        end
    endtask : wait_eval
    task automatic wait_freq(input int ch, input logic [FREQ_W-1:0] old);
        int n;
        n = 0;
        while (freq_filt[ch] === old)
        begin
            @(negedge clk);
            n++;
            if (n > 5000)
            begin
                fail("filter never updated");
                wrap_up();
            end
        end
    endtask : wait_freq
    // Always leave via normal, never jump from clear to force
    task automatic clear_errs;
        @(posedge clk);
        cfg.prog_mode <= 1'b1;
        cfg.fault_injection_setting <= FI_CLEAR;
        repeat (2) @(posedge clk);
        cfg.fault_injection_setting <= FI_NORMAL;
        @(posedge clk);
        cfg.prog_mode <= 1'b0;
    endtask : clear_errs
    task automatic t_power_up;
        int n;
        do_reset(21'h000021);
        cyc(1);
        chk_word(status.err_status, 32'h20, "stored error not shown");
        chk_flag(status.stored_error_at_startup, 1'b1, "startup flag");
        wait_eval(n);
        chk_flag(n >= 3 * MS - 2 && n <= 3 * MS + 4, 1'b1, "power-up delay");
        chk_flag(status.error_out, 1'b1, "stored error output");
        nv_wr_seen = 0;
        @(posedge clk);
        ext_err <= 21'h000080;
        cyc(3);
        chk_word(status.err_status, 32'hA0, "external error");
        chk_word(nv_data, 32'hA1, "record image");
        chk_flag(nv_wr_seen > 0, 1'b1, "record write");
        @(posedge clk);
        ext_err <= '0;
        cyc(5);
        chk_word(status.err_status, 32'hA0, "latch lost");
        clear_errs();
        cyc(2);
        chk_word(status.err_status, 32'h0, "clear");
        chk_word(nv_data, 32'h0, "record not wiped");
        chk_flag(status.stored_error_at_startup, 1'b0, "startup flag kept");
        $display("test power_up done");
    endtask : t_power_up
    task automatic t_cascade;
        int n;
        @(posedge clk);
        cfg.cascade_mode <= 1'b1;
        do_reset(21'h000001);
        cyc(1);
        chk_word(status.err_status, 32'h0, "unmasked record bit shown");
        chk_flag(status.stored_error_at_startup, 1'b0, "unmasked startup flag");
        wait_eval(n);
        chk_flag(n >= 6 * MS - 2 && n <= 6 * MS + 4, 1'b1, "cascade delay");
        @(posedge clk);
        cfg.cascade_mode <= 1'b0;
        $display("test cascade done");
    endtask : t_cascade
    task automatic pos_case(input logic signed [POS_W-1:0] p1, input logic signed [POS_W-1:0] p2, input logic e);
        mmf_sensor_model_i.set_pos(p1, p2);
        cyc(3);
        chk_flag(status.err_status[ERR_BIT_POS], e, "position deviation");
        mmf_sensor_model_i.set_pos('0, '0);
        cyc(3);
        chk_flag(status.err_status[ERR_BIT_POS], e, "position latch");
        clear_errs();
        cyc(2);
        chk_flag(status.err_status[ERR_BIT_POS], 1'b0, "position clear");
    endtask : pos_case
    task automatic t_pos_dev;
        @(posedge clk);
        cfg.pos_limit <= 24'h0003E8;
        pos_case(-32'sh3E8, 32'sh0, 1'b0);
        pos_case(32'sh0, 32'sh3E9, 1'b1);
        pos_case(32'sh3E9, 32'sh0, 1'b1);
        @(posedge clk);
        cfg.pos_limit <= '0;
        pos_case(32'sh7FFFFFFF, -32'sh7FFFFFFF, 1'b0);
        $display("test pos_dev done");
    endtask : t_pos_dev
    task automatic t_inject;
        @(posedge clk);
        cfg.fault_injection_setting <= FI_FORCE;
        cyc(3);
        chk_flag(status.error_out, 1'b0, "forced outside programming");
        @(posedge clk);
        cfg.prog_mode <= 1'b1;
        cyc(3);
        chk_flag(status.error_out, 1'b1, "force");
        @(posedge clk);
        cfg.fault_injection_setting <= FI_NORMAL;
        cyc(3);
        chk_flag(status.error_out, 1'b0, "normal");
        @(posedge clk);
        cfg.prog_mode <= 1'b0;
        $display("test inject done");
    endtask : t_inject
    task automatic t_overlap;
        logic exp_ovl;
        for (int k = 0; k < 2; k++)
            for (int m = 0; m < 3; m++)
                for (int p = 0; p < 4; p++)
                begin
                    @(posedge clk);
                    cfg.sensor_input_type1 <= k ? TYPE_SINGLE_DIR : 2'h2;
                    cfg.sensor_input_type2 <= TYPE_SINGLE_DIR;
                    cfg.overlap_mode <= 2'(m);
                    mmf_sensor_model_i.set_pins(p[0], p[1]);
                    cyc(5);
                    exp_ovl = k == 1 && (m == 1 && p == 0 || m == 2 && p == 3);
                    chk_flag(status.err_status[ERR_BIT_OVL], exp_ovl, "overlap");
                    mmf_sensor_model_i.set_pins(1'b1, 1'b0);
                    cyc(4);
                    clear_errs();
                end
        @(posedge clk);
        cfg.overlap_mode <= OVL_OFF;
        $display("test overlap done");
    endtask : t_overlap
    task automatic t_filter;
        mmf_sensor_model_i.send_freq(0, 24'h001388);
        wait_freq(0, '0);
        chk_word(freq_filt[0], 32'h1388, "unsmoothed");
        @(posedge clk);
        cfg.filter_strength <= 10'h00A;
        mmf_sensor_model_i.send_freq(0, 24'h001770);
        cyc(1000);
        chk_word(freq_filt[0], 32'h1388, "update too early");
        wait_freq(0, 24'h001388);
        chk_word(freq_filt[0], 32'h13EC, "one smoothing step");
        mmf_sensor_model_i.send_freq(1, 24'h0003E8);
        cyc(2);
        chk_flag(filt_busy[1], 1'b1, "filter not busy while dividing");
        wait_freq(1, '0);
        chk_word(freq_filt[1], 32'h64, "second channel step");
        chk_flag(filt_busy[1], 1'b0, "filter busy after update");
        $display("test filter done");
    endtask : t_filter
    initial
    begin
        rst_n = 1'b0;
        cfg = '0;
        cfg.fault_injection_setting = FI_NORMAL;
        cfg.powerup_delay_ms = 15'h0003;
        cfg.cascade_delay_ms = 17'h00006;
        cfg.store_mask = 21'h0000A0;
        ext_err = '0;
        nv_saved = '0;
        t_power_up();
        t_cascade();
        t_pos_dev();
        t_inject();
        t_overlap();
        t_filter();
        wrap_up();
    end
endmodule : mmf_fault_supervisor_tb
`default_nettype wire
